// ===== core/gpd_top.sv
// Purpose: Pull-up and pull-down enable registers for 13 GPIO pins
// Assumes: Register port from the control interface, synchronous inputs
// Notes: Pull enables reach the pad only while the pin is an input
//
// Notes on behaviour
// - Thirteen pull-down enable bits, one per pin
// - Pull-down acts only while pin is input
// - State machine clear zeroes all enable bits
// - Enable bits default to zero at reset
// - Companion pull-up register, same bit positions
`timescale 1ns/10ps
`default_nettype none
module gpd_top
  import gpd_pkg::*;
#(
  parameter int PINS = GPD_PINS
) (
  // Clock, reset, enable
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  // Register port
  input wire logic [GPD_ADDR_W-1:0] REG_ADDR_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  input wire logic [GPD_DATA_W-1:0] REG_WDATA_I,
  output logic [GPD_DATA_W-1:0] REG_RDATA_O,
  // Power state machine clear
  input wire logic SM_CLEAR_I,
  // Pin configuration and pad control
  input wire logic [PINS-1:0] PIN_IS_INPUT_I,
  output logic [PINS-1:0] PULLDOWN_ON_O,
  output logic [PINS-1:0] PULLUP_ON_O,
  output logic PULL_CONFLICT_O
);

  logic [PINS-1:0] pd_reg, pd_next;
  logic [PINS-1:0] pu_reg, pu_next;
  logic [PINS-1:0] pd_on_reg, pd_on_next;
  logic [PINS-1:0] pu_on_reg, pu_on_next;
  logic conflict_reg, conflict_next;
  logic [GPD_DATA_W-1:0] rdata_reg, rdata_next;
  logic wr_pd, wr_pu;

  assign wr_pd = REG_WR_I && (REG_ADDR_I == GPD_PULLDOWN_ADDR);
  assign wr_pu = REG_WR_I && (REG_ADDR_I == GPD_PULLUP_ADDR);

  // Clear beats a same-cycle write: the state machine owns reset
  always_comb begin
    pd_next = pd_reg;
    pu_next = pu_reg;
    if (SM_CLEAR_I) begin
      pd_next = GPD_PULL_RESET;
      pu_next = GPD_PULL_RESET;
    end else begin
      if (wr_pd) begin
        pd_next = REG_WDATA_I[PINS-1:0];
      end
      if (wr_pu) begin
        pu_next = REG_WDATA_I[PINS-1:0];
      end
    end
  end

  // Per-pin gating by direction
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      assign pd_on_next[gi] = pd_reg[gi] & PIN_IS_INPUT_I[gi];
      assign pu_on_next[gi] = pu_reg[gi] & PIN_IS_INPUT_I[gi];
    end
  endgenerate

  // Flag only; the pad keeps both as asked, software must avoid it
  assign conflict_next = |(pd_reg & pu_reg);

  always_comb begin
    rdata_next = rdata_reg;
    if (REG_RD_I) begin
      if (REG_ADDR_I == GPD_PULLDOWN_ADDR) begin
        rdata_next = GPD_RDATA_ZERO;
        rdata_next[PINS-1:0] = pd_reg;
      end else if (REG_ADDR_I == GPD_PULLUP_ADDR) begin
        rdata_next = GPD_RDATA_ZERO;
        rdata_next[PINS-1:0] = pu_reg;
      end else begin
        rdata_next = GPD_RDATA_ZERO;
      end
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pd_reg <= GPD_PULL_RESET;
      pu_reg <= GPD_PULL_RESET;
      pd_on_reg <= GPD_PULL_RESET;
      pu_on_reg <= GPD_PULL_RESET;
      conflict_reg <= 1'b0;
      rdata_reg <= GPD_RDATA_ZERO;
    end else if (CE_I) begin
      pd_reg <= pd_next;
      pu_reg <= pu_next;
      pd_on_reg <= pd_on_next;
      pu_on_reg <= pu_on_next;
      conflict_reg <= conflict_next;
      rdata_reg <= rdata_next;
    end
  end

  assign PULLDOWN_ON_O = pd_on_reg;
  assign PULLUP_ON_O = pu_on_reg;
  assign PULL_CONFLICT_O = conflict_reg;
  assign REG_RDATA_O = rdata_reg;

  // Checks
  // Write then read on the very next cycle sees the new word
  wr_pd_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && wr_pd && !SM_CLEAR_I ##1 CE_I && REG_RD_I &&
    REG_ADDR_I == GPD_PULLDOWN_ADDR && !SM_CLEAR_I && !wr_pd
    |=> REG_RDATA_O[PINS-1:0] == $past(REG_WDATA_I[PINS-1:0], 2))
    else $error("pull-down write not read back");

  rd_pd_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && REG_RD_I && REG_ADDR_I == GPD_PULLDOWN_ADDR
    |=> REG_RDATA_O[PINS-1:0] == $past(pd_reg))
    else $error("pull-down read data wrong");

  // Upper bits of the word have no pin behind them
  rd_upper_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    REG_RDATA_O[GPD_DATA_W-1:PINS] == '0)
    else $error("unused read bits set");

  rd_other_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && REG_RD_I && REG_ADDR_I != GPD_PULLDOWN_ADDR &&
    REG_ADDR_I != GPD_PULLUP_ADDR |=> REG_RDATA_O == '0)
    else $error("other address read not zero");

  // Read data stands until the next accepted read
  rd_hold_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && !REG_RD_I |=> $stable(REG_RDATA_O))
    else $error("read data moved without a read");

  wr_other_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && !SM_CLEAR_I && !wr_pd |=> $stable(pd_reg))
    else $error("pull-down changed without a write");

  gate_dir_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I |=> (PULLDOWN_ON_O & ~$past(PIN_IS_INPUT_I)) == '0)
    else $error("pull-down on a non-input pin");

  gate_on_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && !SM_CLEAR_I && !wr_pd ##1 CE_I
    |=> PULLDOWN_ON_O == ($past(pd_reg) & $past(PIN_IS_INPUT_I)))
    else $error("pull-down not applied to input pin");

  conflict_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I |=> PULL_CONFLICT_O == (($past(pd_reg) & $past(pu_reg)) != '0))
    else $error("conflict flag wrong");

  sm_clear_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && SM_CLEAR_I |=> pd_reg == '0 && pu_reg == '0 ##1
    (!CE_I || PULLDOWN_ON_O == '0))
    else $error("clear left enables set");

  // A write racing the clear must lose
  clr_wins_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && SM_CLEAR_I && wr_pd |=> pd_reg == '0)
    else $error("write beat the clear");

  reset_dflt_a: assert property (
    @(posedge CLK_I)
    $fell(RESET_I) |-> pd_reg == '0 && pu_reg == '0 &&
    PULLDOWN_ON_O == '0)
    else $error("enables not zero after reset");

  wr_pu_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && wr_pu && !SM_CLEAR_I |=> pu_reg == $past(REG_WDATA_I[PINS-1:0]))
    else $error("pull-up write lost");

  pu_read_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I && REG_RD_I && REG_ADDR_I == GPD_PULLUP_ADDR
    |=> REG_RDATA_O[PINS-1:0] == $past(pu_reg))
    else $error("pull-up read data wrong");

  pu_gate_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    CE_I |=> (PULLUP_ON_O & ~$past(PIN_IS_INPUT_I)) == '0)
    else $error("pull-up on a non-input pin");

  freeze_a: assert property (
    @(posedge CLK_I) disable iff (RESET_I)
    !CE_I |=> $stable(pd_reg) && $stable(REG_RDATA_O))
    else $error("state moved with enable low");

  pd_apply_c: cover property (@(posedge CLK_I) disable iff (RESET_I)
    CE_I && wr_pd ##2 PULLDOWN_ON_O != '0);
  conflict_c: cover property (@(posedge CLK_I) disable iff (RESET_I)
    $rose(PULL_CONFLICT_O));
  clear_c: cover property (@(posedge CLK_I) disable iff (RESET_I)
    pd_reg != '0 ##1 CE_I && SM_CLEAR_I);
  b2b_c: cover property (@(posedge CLK_I) disable iff (RESET_I)
    CE_I && wr_pd ##1 CE_I && REG_RD_I && !wr_pd);
  freeze_c: cover property (@(posedge CLK_I) disable iff (RESET_I)
    !CE_I && REG_WR_I ##1 CE_I);

endmodule
`default_nettype wire

// ===== core/gpd_pkg.sv
// Purpose: Constants for the GPIO pull-down control block
// Assumes: 16-bit register words, 13 GPIO pins
// Notes: Addresses are the device's register numbers
package gpd_pkg;
  localparam int GPD_PINS = 13;
  localparam int GPD_ADDR_W = 8;
  localparam int GPD_DATA_W = 16;
  localparam logic [7:0] GPD_PULLUP_ADDR = 8'h81;
  localparam logic [7:0] GPD_PULLDOWN_ADDR = 8'h82;
  localparam logic [12:0] GPD_PULL_RESET = 13'h0000;
  localparam logic [15:0] GPD_RDATA_ZERO = 16'h0000;
endpackage

// ===== verif/gpio_pulldown_control_test.sv
// Purpose: Self-checking bench for the GPIO pull enable block
// Assumes: One-cycle read latency, pads one cycle behind registers
// Notes: Clock enable high except in the freeze test; pins all inputs until the bit test sets 13'h0aa5
`timescale 1ns/10ps
`default_nettype none
module gpio_pulldown_control_test;
  logic clk = 0, rst = 1, wr = 0, rd = 0, clr = 0, ce = 1, cf;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [12:0] pins = 13'h1fff, pd, pu;
  int num_errors = 0, tests_run = 0;
  gpd_top dut_u (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .SM_CLEAR_I(clr),
    .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd), .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata), .PIN_IS_INPUT_I(pins), .PULLDOWN_ON_O(pd),
    .PULLUP_ON_O(pu), .PULL_CONFLICT_O(cf));
  initial forever #5 clk = ~clk;
  initial begin
    repeat (3000) @(posedge clk);
    num_errors++;
    test_done;
  end
  task automatic chk(string what, logic [15:0] exp, got);
    tests_run++;
    num_errors += int'(got !== exp);
    if (got !== exp) $display("unexpected %s exp %h got %h", what, exp, got);
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
    {addr, wdata, wr, rd} = {a, d, w, !w};
    @(posedge clk) #1 {wr, rd} = 2'h0;
    @(posedge clk) #1;
    if (!w) chk("read data", d, rdata);
  endtask
  task automatic pads(logic [12:0] e_pd, e_pu, logic e_cf);
    chk("pulldown pads", 16'(e_pd), 16'(pd));
    chk("pullup pads", 16'(e_pu), 16'(pu));
    chk("conflict flag", 16'(e_cf), 16'(cf));
  endtask
  task automatic all_zero;
    bus(0, 8'h82, 16'h0000);
    bus(0, 8'h81, 16'h0000);
    pads(13'h0000, 13'h0000, 1'h0);
  endtask
  task automatic t_bits;
    for (int n = 0; n < 13; n++) begin
      bus(1, 8'h82, 16'he000 | (16'h0001 << n));
      bus(0, 8'h82, 16'h0001 << n);
      pads(13'h0001 << n, 13'h0000, 1'h0);
    end
    pins = 13'h0aa5;
    repeat (2) @(posedge clk) #1;
    pads(13'h0000, 13'h0000, 1'h0);
    $display("bit test done");
  endtask
  task automatic t_pair;
    bus(1, 8'h81, 16'h0003);
    pads(13'h0000, 13'h0001, 1'h0);
    bus(1, 8'h82, 16'h0001);
    pads(13'h0001, 13'h0001, 1'h1);
    bus(0, 8'h83, 16'h0000);
    $display("pair test done");
  endtask
  task automatic t_clear;
    {addr, wdata, wr, clr} = {8'h82, 16'h1fff, 2'b11};
    @(posedge clk) #1 {wr, clr} = 2'b00;
    all_zero;
    $display("clear test done");
  endtask
  task automatic t_b2b;
    {addr, wdata, wr, rd} = {8'h82, 16'h0004, 2'b10};
    @(posedge clk) #1 {wdata, wr, rd} = {16'h0008, 2'b11};
    @(posedge clk) #1 {wr, rd} = 2'b01;
    chk("read old", 16'h0004, rdata);
    @(posedge clk) #1 rd = 0;
    chk("read new", 16'h0008, rdata);
    $display("back to back test done");
  endtask
  task automatic t_freeze;
    ce = 0;
    bus(1, 8'h82, 16'h0001);
    ce = 1;
    bus(0, 8'h82, 16'h0008);
    pads(13'h0000, 13'h0000, 1'h0);
    $display("freeze test done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rst = 0;
    all_zero;
    $display("reset test done");
    t_bits;
    t_pair;
    t_clear;
    t_b2b;
    t_freeze;
    test_done;
  end
endmodule
`default_nettype wire
